/* File: rtl/jpm_defs.vh */
// Register indices, field positions, reset values and timing for jpm
`ifndef JPM_DEFS_VH
`define JPM_DEFS_VH

// Register indices; byte address is four times the index
`define JPM_IDX_ERR_LO 12'h023
`define JPM_IDX_ERR_HI 12'h024
`define JPM_IDX_CFG 12'h7E5
`define JPM_IDX_POS_LO 12'h7E6
`define JPM_IDX_POS_HI 12'h7E7
`define JPM_IDX_NEG_LO 12'h7E8
`define JPM_IDX_NEG_HI 12'h7E9

// Byte address width in bits
`define JPM_ADDR_W 14

// Configuration fields
`define JPM_CFG_BW_BIT 0
`define JPM_CFG_MODE_BIT 1
`define JPM_CFG_STOP_BIT 2
`define JPM_CFG_W 3
`define JPM_CFG_RST 3'h0

// Result reset values
`define JPM_BYTE_RST 8'h00
`define JPM_PEAK_RST 12'h000

// Automatic period: one second at a 100 MHz clock
`define JPM_PERIOD_S 1
`define JPM_CLK_HZ 100000000
`define JPM_PERIOD_CYC (`JPM_PERIOD_S * `JPM_CLK_HZ)

// Bus responses
`define JPM_RESP_OKAY 2'h0
`define JPM_RESP_SLVERR 2'h2

`endif

/* File: rtl/jpm_peak.v */
// Positive and negative jitter peak tracker for one measurement round
`timescale 1ns/1ns
`default_nettype none

module jpm_peak #(
   parameter W = 12
) (
   input wire aclk,
   input wire aresetn,
   input wire restart,
   input wire sample_valid,
   input wire signed [W:0] sample,
   output reg [W-1:0] pos_peak_r,
   output reg [W-1:0] neg_peak_r
);

   wire is_neg;
   wire [W:0] neg_mag;
   wire [W-1:0] pos_val;
   wire [W-1:0] neg_val;

   // Split the sample into a positive height and a negative depth
   assign is_neg = sample[W];
   assign neg_mag = (~sample) + {{W{1'b0}}, 1'b1};
   assign pos_val = is_neg ? {W{1'b0}} : sample[W-1:0];
   assign neg_val = !is_neg ? {W{1'b0}} :
                    (neg_mag[W] ? {W{1'b1}} : neg_mag[W-1:0]);

   // Hold the greatest heights; a restart starts from the current sample
   always @(posedge aclk) begin
      if (!aresetn) begin
         pos_peak_r <= {W{1'b0}};
         neg_peak_r <= {W{1'b0}};
      end else if (restart) begin
         pos_peak_r <= sample_valid ? pos_val : {W{1'b0}};
         neg_peak_r <= sample_valid ? neg_val : {W{1'b0}};
      end else if (sample_valid) begin
         if (pos_val > pos_peak_r) begin
            pos_peak_r <= pos_val;
         end
         if (neg_val > neg_peak_r) begin
            neg_peak_r <= neg_val;
         end
      end
   end

endmodule

`default_nettype wire

/* File: rtl/jpm_top.v */
// Channel-0 jitter peak measurement with AXI4-Lite register access
//
// How it works
// - Upper error-count byte is a read-only register resetting to zero.
// - Both error-count bytes latch the counter per round, overwriting the old.
// - Period mode 0, the default, ends rounds by software writing stop from 0 to 1.
// - Period mode 1 ends rounds every second and updates results.
// - Bandwidth bit selects the jitter filter band, driven to the filter.
// - Greatest positive peak held as twelve bits over two registers.
// - Result registers refresh automatically or on manual stop per mode.
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
`include "jpm_defs.vh"

module jpm_top #(
   parameter PEAK_W = 12,
   parameter PERIOD_CYC = `JPM_PERIOD_CYC,
   parameter CNT_W = 27
) (
   input wire aclk,
   input wire aresetn,
   input wire [`JPM_ADDR_W-1:0] s_axi_awaddr,
   input wire [2:0] s_axi_awprot,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [`JPM_ADDR_W-1:0] s_axi_araddr,
   input wire [2:0] s_axi_arprot,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire signed [PEAK_W:0] jitter_sample,
   input wire jitter_valid,
   input wire [15:0] error_count_in,
   input wire error_round_done,
   output reg bandwidth_select_r
);

   reg [`JPM_ADDR_W-1:0] awaddr_r;
   reg aw_hold_r;
   reg [31:0] wdata_r;
   reg [3:0] wstrb_r;
   reg w_hold_r;
   reg [`JPM_CFG_W-1:0] cfg_r;
   reg [7:0] err_lo_r;
   reg [7:0] err_hi_r;
   reg [PEAK_W-1:0] pos_res_r;
   reg [PEAK_W-1:0] neg_res_r;
   reg [CNT_W-1:0] sec_cnt_r;
   reg manual_end_r;
   wire auto_end;
   wire round_end;
   wire [PEAK_W-1:0] pos_peak;
   wire [PEAK_W-1:0] neg_peak;
   wire [11:0] wr_idx;
   wire [11:0] rd_idx;
   wire do_write;
   wire cfg_hit;
   wire stop_rise;
   reg [31:0] rd_mux;
   reg rd_ok;

   // Last count of a period, cut to the counter width on purpose
   localparam integer LAST_INT = PERIOD_CYC - 1;
   localparam [CNT_W-1:0] LAST_CYC = LAST_INT[CNT_W-1:0];

   assign wr_idx = awaddr_r[13:2];
   assign rd_idx = s_axi_araddr[13:2];
   assign do_write = aw_hold_r && w_hold_r && !s_axi_bvalid;
   assign cfg_hit = do_write && (wr_idx == `JPM_IDX_CFG) && wstrb_r[0];
   // Stop bit written from 0 to 1 while in manual mode
   assign stop_rise = cfg_hit && wdata_r[`JPM_CFG_STOP_BIT] &&
                      !cfg_r[`JPM_CFG_STOP_BIT] &&
                      !cfg_r[`JPM_CFG_MODE_BIT];

   // One-second period end in automatic mode
   assign auto_end = cfg_r[`JPM_CFG_MODE_BIT] && (sec_cnt_r == LAST_CYC);
   assign round_end = auto_end || manual_end_r;

   // Peak tracking restarts at each round end
   jpm_peak #(
      .W(PEAK_W)
   ) u_peak (
      .aclk(aclk),
      .aresetn(aresetn),
      .restart(round_end),
      .sample_valid(jitter_valid),
      .sample(jitter_sample),
      .pos_peak_r(pos_peak),
      .neg_peak_r(neg_peak)
   );

   // Period counter runs only in automatic mode
   always @(posedge aclk) begin
      if (!aresetn) begin
         sec_cnt_r <= {CNT_W{1'b0}};
      end else if (!cfg_r[`JPM_CFG_MODE_BIT] || auto_end) begin
         sec_cnt_r <= {CNT_W{1'b0}};
      end else begin
         sec_cnt_r <= sec_cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
      end
   end

   // Result latches; each new round overwrites the previous one
   always @(posedge aclk) begin
      if (!aresetn) begin
         pos_res_r <= `JPM_PEAK_RST;
         neg_res_r <= `JPM_PEAK_RST;
         err_lo_r <= `JPM_BYTE_RST;
         err_hi_r <= `JPM_BYTE_RST;
         manual_end_r <= 1'b0;
      end else begin
         manual_end_r <= stop_rise;
         if (round_end) begin
            pos_res_r <= pos_peak;
            neg_res_r <= neg_peak;
         end
         if (error_round_done) begin
            err_lo_r <= error_count_in[7:0];
            err_hi_r <= error_count_in[15:8];
         end
      end
   end

   // Write channel: address and data taken in either order
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         awaddr_r <= {`JPM_ADDR_W{1'b0}};
         wdata_r <= 32'h00000000;
         wstrb_r <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `JPM_RESP_OKAY;
         cfg_r <= `JPM_CFG_RST;
         bandwidth_select_r <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awaddr_r <= s_axi_awaddr;
            aw_hold_r <= 1'b1;
            s_axi_awready <= 1'b0;
         end else if (!aw_hold_r && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
            w_hold_r <= 1'b1;
            s_axi_wready <= 1'b0;
         end else if (!w_hold_r && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
         end
         if (do_write) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            case (wr_idx)
               `JPM_IDX_ERR_LO, `JPM_IDX_ERR_HI, `JPM_IDX_CFG,
               `JPM_IDX_POS_LO, `JPM_IDX_POS_HI,
               `JPM_IDX_NEG_LO, `JPM_IDX_NEG_HI: begin
                  s_axi_bresp <= `JPM_RESP_OKAY;
               end
               default: begin
                  s_axi_bresp <= `JPM_RESP_SLVERR;
               end
            endcase
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         // Only the configuration byte is writable
         if (cfg_hit) begin
            cfg_r <= wdata_r[`JPM_CFG_W-1:0];
            bandwidth_select_r <= wdata_r[`JPM_CFG_BW_BIT];
         end
      end
   end

   // Read data selection; reserved bits read as zero
   always @* begin
      rd_mux = 32'h00000000;
      rd_ok = 1'b1;
      case (rd_idx)
         `JPM_IDX_ERR_LO: rd_mux[7:0] = err_lo_r;
         `JPM_IDX_ERR_HI: rd_mux[7:0] = err_hi_r;
         `JPM_IDX_CFG: rd_mux[`JPM_CFG_W-1:0] = cfg_r;
         `JPM_IDX_POS_LO: rd_mux[7:0] = pos_res_r[7:0];
         `JPM_IDX_POS_HI: rd_mux[3:0] = pos_res_r[11:8];
         `JPM_IDX_NEG_LO: rd_mux[7:0] = neg_res_r[7:0];
         `JPM_IDX_NEG_HI: rd_mux[3:0] = neg_res_r[11:8];
         default: rd_ok = 1'b0;
      endcase
   end

   // Read channel: one read under way at a time
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `JPM_RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_ok ? `JPM_RESP_OKAY : `JPM_RESP_SLVERR;
         end else begin
            if (!s_axi_rvalid) begin
               s_axi_arready <= 1'b1;
            end
            if (s_axi_rvalid && s_axi_rready) begin
               s_axi_rvalid <= 1'b0;
            end
         end
      end
   end

endmodule

`default_nettype wire

/* File: bench/jpm_checker.sv */
// Assertions on bus handshakes and read results of jpm_top
`timescale 1ns/1ns
`default_nettype none
`include "jpm_defs.vh"
module jpm_checker (
   input wire aclk,
   input wire aresetn,
   input wire [`JPM_ADDR_W-1:0] s_axi_araddr,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   input wire s_axi_awready,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire [15:0] error_count_in,
   input wire error_round_done,
   input wire bandwidth_select_r
);
   reg [11:0] idx_r;
   reg [7:0] ehi_r;
   reg [7:0] elo_r;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Last read index and the error count last latched
   always @(posedge aclk) begin
      if (!aresetn) begin
         idx_r <= 12'h000;
         ehi_r <= 8'h00;
         elo_r <= 8'h00;
      end else begin
         if (s_axi_arvalid && s_axi_arready)
            idx_r <= s_axi_araddr[13:2];
         if (error_round_done)
            {ehi_r, elo_r} <= error_count_in;
      end
   end
   err_hi_a: assert property ($rose(s_axi_rvalid)
      && idx_r == `JPM_IDX_ERR_HI |-> s_axi_rdata == {24'h000000,
      $past(ehi_r)}) else $error("error high byte wrong");
   err_lo_a: assert property ($rose(s_axi_rvalid)
      && idx_r == `JPM_IDX_ERR_LO |-> s_axi_rdata == {24'h000000,
      $past(elo_r)}) else $error("error low byte wrong");
   pos_hi_a: assert property ($rose(s_axi_rvalid)
      && idx_r == `JPM_IDX_POS_HI |-> s_axi_rdata[31:4] == 28'h0
      && s_axi_rresp == `JPM_RESP_OKAY) else $error("peak high wrong");
   cfg_rd_a: assert property ($rose(s_axi_rvalid)
      && idx_r == `JPM_IDX_CFG |-> s_axi_rdata[31:3] == 29'h0
      && s_axi_rdata[0] == $past(bandwidth_select_r))
      else $error("config readback wrong");
   bw_chg_a: assert property ($changed(bandwidth_select_r)
      |-> $rose(s_axi_bvalid)) else $error("band changed without write");
   wr_busy_a: assert property (s_axi_bvalid
      |-> !s_axi_awready && !s_axi_wready) else $error("ready during b");
   rd_lat_a: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid) else $error("read answer late");
   rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("arready during r");
   cover property ($rose(s_axi_rvalid) && idx_r == `JPM_IDX_POS_LO);
   cover property ($rose(bandwidth_select_r));
   cover property (error_round_done);
endmodule
bind jpm_top jpm_checker jpm_checker_inst (.aclk, .aresetn,
   .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rresp, .s_axi_rvalid, .s_axi_awready, .s_axi_wready,
   .s_axi_bvalid, .error_count_in, .error_round_done,
   .bandwidth_select_r);
`default_nettype wire

/* File: bench/jpm_top_tb_top.sv */
// Self-checking bench for the jitter peak measurement block
`timescale 1ns/1ns
`default_nettype none
`include "jpm_defs.vh"
module jpm_top_tb_top;
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_rready, jitter_valid, error_round_done;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, bandwidth_select_r;
   logic [13:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic signed [12:0] jitter_sample;
   logic [15:0] error_count_in;
   logic [31:0] rd;
   int errors = 0, compares = 0, cyc = 0;
   localparam logic [1:0] OK = `JPM_RESP_OKAY, SE = `JPM_RESP_SLVERR;
   jpm_top #(.PERIOD_CYC(50)) jpm_top_inst (.*);
   // Clock
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   // Hang guard
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         errors++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      if (errors == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
      end
   endtask
   // Write: address and data held until each is taken
   task automatic wc(input logic [11:0] i, input logic [31:0] d,
         input logic [1:0] r);
      s_axi_awaddr <= {i, 2'b00};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid)
            break;
      end
      chk({32'h0, s_axi_bresp}, {32'h0, r});
   endtask
   // Read and compare data and response
   task automatic rc(input logic [11:0] i, input logic [31:0] d,
         input logic [1:0] r);
      s_axi_araddr <= {i, 2'b00};
      s_axi_arvalid <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid)
            break;
      end
      chk({s_axi_rresp, s_axi_rdata}, {r, d});
   endtask
   task automatic samp(input logic signed [12:0] s);
      jitter_sample <= s;
      jitter_valid <= 1'b1;
      @(posedge aclk);
      jitter_valid <= 1'b0;
      repeat (2) @(posedge aclk);
   endtask
   task automatic errp(input logic [15:0] v);
      error_count_in <= v;
      error_round_done <= 1'b1;
      @(posedge aclk);
      error_round_done <= 1'b0;
      @(posedge aclk);
   endtask
   // Main sequence
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
      {jitter_valid, error_round_done} = 2'h0;
      {s_axi_bready, s_axi_rready} = 2'h3;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 60'h0;
      jitter_sample = 13'h0000;
      error_count_in = 16'h0000;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      rc(`JPM_IDX_ERR_LO, 32'h0, OK);
      rc(`JPM_IDX_ERR_HI, 32'h0, OK);
      rc(`JPM_IDX_CFG, 32'h0, OK);
      rc(`JPM_IDX_POS_LO, 32'h0, OK);
      rc(`JPM_IDX_POS_HI, 32'h0, OK);
      rc(12'h000, 32'h0, SE);
      wc(12'h000, 32'h1, SE);
      errp(16'hA55A);
      rc(`JPM_IDX_ERR_LO, 32'h5A, OK);
      wc(`JPM_IDX_ERR_HI, 32'hFF, OK);
      rc(`JPM_IDX_ERR_HI, 32'hA5, OK);
      errp(16'h1234);
      rc(`JPM_IDX_ERR_HI, 32'h12, OK);
      wc(`JPM_IDX_CFG, 32'h1, OK);
      chk({33'h0, bandwidth_select_r}, 34'h1);
      rc(`JPM_IDX_CFG, 32'h1, OK);
      samp(13'sd100);
      samp(13'sd700);
      samp(-13'sd300);
      wc(`JPM_IDX_CFG, 32'h4, OK);
      chk({33'h0, bandwidth_select_r}, 34'h0);
      repeat (2) @(posedge aclk);
      rc(`JPM_IDX_POS_LO, 32'hBC, OK);
      rc(`JPM_IDX_POS_HI, 32'h2, OK);
      rc(`JPM_IDX_NEG_LO, 32'h2C, OK);
      rc(`JPM_IDX_NEG_HI, 32'h1, OK);
      samp(13'sd50);
      wc(`JPM_IDX_CFG, 32'h4, OK);
      repeat (2) @(posedge aclk);
      rc(`JPM_IDX_POS_LO, 32'hBC, OK);
      wc(`JPM_IDX_CFG, 32'h0, OK);
      wc(`JPM_IDX_CFG, 32'h4, OK);
      repeat (2) @(posedge aclk);
      rc(`JPM_IDX_POS_LO, 32'h32, OK);
      rc(`JPM_IDX_NEG_LO, 32'h0, OK);
      wc(`JPM_IDX_CFG, 32'h2, OK);
      samp(13'sd900);
      repeat (54) @(posedge aclk);
      rc(`JPM_IDX_POS_LO, 32'h84, OK);
      rc(`JPM_IDX_POS_HI, 32'h3, OK);
      samp(13'sd40);
      repeat (49) @(posedge aclk);
      rc(`JPM_IDX_POS_LO, 32'h28, OK);
      // Second reset in mid-run; upper error byte, positive peak low byte and configuration read back zero
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      rc(`JPM_IDX_ERR_HI, 32'h0, OK);
      rc(`JPM_IDX_POS_LO, 32'h0, OK);
      rc(`JPM_IDX_CFG, 32'h0, OK);
      print_verdict();
   end
endmodule
`default_nettype wire
